// ---- pkg/cmd_regs_pkg.sv ----
// Package for the codec command and status register bank.
// Assumes an 8-bit host bus with four address lines.
`default_nettype none
package cmd_regs_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  // Register addresses
  localparam logic [3:0] ADDR_INT_ENABLE = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_OP_MODE = 4'h2;
  localparam logic [3:0] ADDR_CODING_METHOD = 4'h3;
  localparam logic [3:0] ADDR_LINE_PIXELS = 4'h4;
  localparam logic [3:0] ADDR_LINE_MEMORY = 4'h5;
  localparam logic [3:0] ADDR_SOFT_RESET = 4'h6;
  localparam logic [3:0] ADDR_OUT_FORMAT = 4'h8;
  // Field positions
  localparam int BIT_LINE_DONE = 0;
  localparam int BIT_CODE_DONE = 1;
  localparam int BIT_REC_READY = 2;
  localparam int BIT_IMG_READY = 3;
  localparam int BIT_SOFT_RESET = 0;
  localparam int BIT_TWO_DIM = 0;
  localparam int STATUS_FLAGS = 4;
  // Reset values
  localparam logic [7:0] RESET_CMD = 8'h00;
  // Host bus strobes carried together
  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [3:0] addr;
  } host_bus_type;
  // Flags from the coding engine
  typedef struct packed {
    logic img_ready;
    logic rec_ready;
    logic code_done;
    logic line_done;
  } status_in_type;
endpackage
`default_nettype wire

// ---- rtl/cmd_reg8.sv ----
// One 8-bit write-only command register.
// Assumes a write enable synchronous to clk_sys; it may stay high for several cycles.
`timescale 1ns/1ns
`default_nettype none
module cmd_reg8
  import cmd_regs_pkg::*;
#(
  parameter logic [7:0] RESET_VALUE = RESET_CMD
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] value_r
);
  logic [7:0] value_nxt;

  // Take the host byte on a write
  always_comb begin
    value_nxt = wr_en ? wr_data : value_r;
  end

  // Defined reset value
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      value_r <= RESET_VALUE;
    end else begin
      value_r <= value_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/cmd_status_regs.sv ----
// Host-visible command and status register bank of the fax codec.
// Assumes host strobes are active-high pulses already synchronous to clk_sys.
// Registers are reached only through the host pins; there is no other bus.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Each register decoded at its fixed address
// - All registers take defined reset values
// - Soft reset bit holds controller in reset
// - One interrupt enable bit per source
// - Status bits zero and one report completion
// - Status bits two and three report ready
// - Coding bit selects one or two dimensional
// - Pixel register sets count and reduction
// - Format register configures recorder output data
// - Drive interrupt request toward host
// - Eight-bit data bus, driven only on reads
module cmd_status_regs
  import cmd_regs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire host_bus_type host_bus,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  input wire status_in_type status_in,
  output logic int_req,
  output logic ctrl_reset,
  output logic two_dim_coding,
  output logic [7:0] op_mode,
  output logic [7:0] line_pixels,
  output logic [7:0] line_memory,
  output logic [7:0] out_format
);
  // Command register contents; only the documented low bits steer anything
  logic [7:0] int_enable_r;
  logic [7:0] soft_reset_r;
  logic [7:0] coding_r;
  // Read byte register and its next value
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  // Engine flags gathered in status bit order
  logic [STATUS_FLAGS-1:0] flags;
  // Host strobes qualified by chip select
  logic wr_stb;
  logic rd_stb;
  // One write select per command register
  logic wr_int_enable;
  logic wr_op_mode;
  logic wr_coding;
  logic wr_line_pixels;
  logic wr_line_memory;
  logic wr_soft_reset;
  logic wr_out_format;
  // High while the address lines point at the status register
  logic rd_status;

  // Strobes qualified by chip select; host keeps to the pin protocol
  assign wr_stb = host_bus.cs && host_bus.wr;
  assign rd_stb = host_bus.cs && host_bus.rd;

  // Write address decode. A held write strobe rewrites the same byte on each
  // edge, which is harmless because the host holds the data lines with it.
  always_comb begin
    wr_int_enable = 1'b0;
    wr_op_mode = 1'b0;
    wr_coding = 1'b0;
    wr_line_pixels = 1'b0;
    wr_line_memory = 1'b0;
    wr_soft_reset = 1'b0;
    wr_out_format = 1'b0;
    if (wr_stb) begin
      case (host_bus.addr)
        ADDR_INT_ENABLE: wr_int_enable = 1'b1;
        ADDR_OP_MODE: wr_op_mode = 1'b1;
        ADDR_CODING_METHOD: wr_coding = 1'b1;
        ADDR_LINE_PIXELS: wr_line_pixels = 1'b1;
        ADDR_LINE_MEMORY: wr_line_memory = 1'b1;
        ADDR_SOFT_RESET: wr_soft_reset = 1'b1;
        ADDR_OUT_FORMAT: wr_out_format = 1'b1;
        default: begin
          // Status address and holes take no write
        end
      endcase
    end
  end

  // Read address decode: only the status address returns data
  always_comb begin
    rd_status = 1'b0;
    case (host_bus.addr)
      ADDR_STATUS: rd_status = 1'b1;
      default: rd_status = 1'b0;
    endcase
  end

  // Interrupt enables, bit n gating status flag n
  cmd_reg8 #(
    .RESET_VALUE(RESET_CMD)
  ) u_int_enable (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(wr_int_enable),
    .wr_data(host_data_in),
    .value_r(int_enable_r)
  );

  // Operating mode byte, passed to the engine as written
  cmd_reg8 #(
    .RESET_VALUE(RESET_CMD)
  ) u_op_mode (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(wr_op_mode),
    .wr_data(host_data_in),
    .value_r(op_mode)
  );

  // Coding method byte; bit 0 picks two-dimensional coding
  cmd_reg8 #(
    .RESET_VALUE(RESET_CMD)
  ) u_coding (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(wr_coding),
    .wr_data(host_data_in),
    .value_r(coding_r)
  );

  // Pixel count and reduction ratio for the input line memory
  cmd_reg8 #(
    .RESET_VALUE(RESET_CMD)
  ) u_line_pixels (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(wr_line_pixels),
    .wr_data(host_data_in),
    .value_r(line_pixels)
  );

  // Line memory allocation for the engine
  cmd_reg8 #(
    .RESET_VALUE(RESET_CMD)
  ) u_line_memory (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(wr_line_memory),
    .wr_data(host_data_in),
    .value_r(line_memory)
  );

  // Soft reset byte; bit 0 holds the controller in reset
  cmd_reg8 #(
    .RESET_VALUE(RESET_CMD)
  ) u_soft_reset (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(wr_soft_reset),
    .wr_data(host_data_in),
    .value_r(soft_reset_r)
  );

  // Recorder output format byte
  cmd_reg8 #(
    .RESET_VALUE(RESET_CMD)
  ) u_out_format (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(wr_out_format),
    .wr_data(host_data_in),
    .value_r(out_format)
  );

  // Controller stays in reset until the host writes the bit back to 0
  assign ctrl_reset = soft_reset_r[BIT_SOFT_RESET];

  // Coding method select toward the engine
  assign two_dim_coding = coding_r[BIT_TWO_DIM];

  // Live status flags from the engine, each at its own bit position
  assign flags[BIT_LINE_DONE] = status_in.line_done;
  assign flags[BIT_CODE_DONE] = status_in.code_done;
  assign flags[BIT_REC_READY] = status_in.rec_ready;
  assign flags[BIT_IMG_READY] = status_in.img_ready;

  // Interrupt is the OR of enabled flags. No latching: the engine holds each
  // flag until serviced, so a source that only pulses would be missed here.
  assign int_req = |(flags & int_enable_r[STATUS_FLAGS-1:0]);

  // Read mux: only the status address returns data, upper bits read zero.
  // The byte is resampled on every read edge, so a held strobe tracks live flags.
  always_comb begin
    rd_data_nxt = rd_data_r;
    if (rd_stb) begin
      if (rd_status) begin
        rd_data_nxt = {4'h0, flags};
      end else begin
        rd_data_nxt = 8'h00;
      end
    end
  end

  // Read data held in a register so the bus sees a settled byte; it keeps
  // its value between reads, so the data lines never move while idle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_r <= 8'h00;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // Registered read byte toward the data lines
  assign host_data_out = rd_data_r;

  // Drive the bus only during a read strobe; drops with chip select
  assign host_data_oe = rd_stb;
endmodule
`default_nettype wire

// ---- dv/host_cpu_model.sv ----
// Host processor model that owns the register bus.
// Assumes tasks are entered 1 ns after a rising edge of clk_sys.
`timescale 1ns/1ns
`default_nettype none
module host_cpu_model
  import cmd_regs_pkg::*;
(
  input wire logic clk_sys,
  output host_bus_type host_bus,
  output logic [7:0] host_data_in
);
  initial host_bus = '0;
  initial host_data_in = 8'h00;
  // Strobes held for two edges, then released; data never idles on a stale value
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    host_bus = '{1'b1, !w, w, a};
    host_data_in = w ? d : ~host_data_in;
    repeat (2) @(posedge clk_sys);
    #1 host_bus.cs = 1'b0;
    host_data_in = ~host_data_in;
    @(posedge clk_sys);
    #1;
  endtask
endmodule
`default_nettype wire

// ---- dv/cmd_status_regs_props.sv ----
// Port checker for the register bank.
// Assumes the bind below reaches every bank instance.
`timescale 1ns/1ns
`default_nettype none
module cmd_status_regs_props
  import cmd_regs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire host_bus_type host_bus,
  input wire logic [7:0] host_data_in,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe,
  input wire status_in_type status_in,
  input wire logic int_req,
  input wire logic ctrl_reset,
  input wire logic [7:0] line_pixels
);
  // Decoded strokes; a read is judged at its first edge only
  logic we, rs;
  logic [3:0] ad;
  assign we = host_bus.cs && host_bus.wr;
  assign rs = host_bus.cs && host_bus.rd;
  assign ad = host_bus.addr;
  // Shadow of the enables the host wrote, to judge the interrupt output
  logic [3:0] en_seen_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      en_seen_r <= 4'h0;
    end else if (we && ad == ADDR_INT_ENABLE) begin
      en_seen_r <= host_data_in[3:0];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_oe; host_data_oe == rs; endproperty
  a_oe: assert property (p_oe) else $error("oe bad");
  property p_srst; we && ad == 4'h6 |=> ctrl_reset == $past(host_data_in[0]); endproperty
  a_srst: assert property (p_srst) else $error("srst bad");
  property p_hold; ctrl_reset && !we |=> ctrl_reset; endproperty
  a_hold: assert property (p_hold) else $error("hold bad");
  property p_pix; we && ad == 4'h4 |=> line_pixels == $past(host_data_in); endproperty
  a_pix: assert property (p_pix) else $error("pix bad");
  property p_sts;
    rs && !$past(rs) && ad == 4'h1 |=> host_data_out == {4'h0, $past(status_in)};
  endproperty
  a_sts: assert property (p_sts) else $error("sts bad");
  property p_ref; rs && !$past(rs) && ad != 4'h1 |=> host_data_out == 8'h00; endproperty
  a_ref: assert property (p_ref) else $error("ref bad");
  property p_idle; !rs |=> $stable(host_data_out); endproperty
  a_idle: assert property (p_idle) else $error("idle bad");
  property p_int; int_req == |(status_in & en_seen_r); endproperty
  a_int: assert property (p_int) else $error("int bad");
  c_rd: cover property (rs && ad == 4'h1);
  c_int: cover property (int_req);
  c_srst: cover property (ctrl_reset);
endmodule
bind cmd_status_regs cmd_status_regs_props u_props (
  .clk_sys(clk_sys),
  .reset_n(reset_n),
  .host_bus(host_bus),
  .host_data_in(host_data_in),
  .host_data_out(host_data_out),
  .host_data_oe(host_data_oe),
  .status_in(status_in),
  .int_req(int_req),
  .ctrl_reset(ctrl_reset),
  .line_pixels(line_pixels)
);
`default_nettype wire

// ---- dv/cmd_status_regs_tb.sv ----
// Bench: host model on the bus, random status flags from the bench.
// Assumes a watcher checks each read when output enable drops.
`timescale 1ns/1ns
`default_nettype none
module cmd_status_regs_tb
  import cmd_regs_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  host_bus_type host_bus;
  logic [7:0] host_data_in, host_data_out, op_mode, line_pixels, line_memory, out_format;
  logic host_data_oe, int_req, ctrl_reset, two_dim_coding;
  status_in_type status_in = '0;
  logic [7:0] exp_q[$];
  logic [7:0] v[6];
  logic [3:0] adr[6] = '{4'h2, 4'h4, 4'h5, 4'h8, 4'h3, 4'h1};
  logic [31:0] seed = 32'hE1455843;
  int n_fail = 0;
  int cmp_count = 0;
  host_cpu_model u_host_cpu_model (
    .clk_sys(clk_sys),
    .host_bus(host_bus),
    .host_data_in(host_data_in)
  );
  cmd_status_regs u_cmd_status_regs (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .host_bus(host_bus),
    .host_data_in(host_data_in),
    .host_data_out(host_data_out),
    .host_data_oe(host_data_oe),
    .status_in(status_in),
    .int_req(int_req),
    .ctrl_reset(ctrl_reset),
    .two_dim_coding(two_dim_coding),
    .op_mode(op_mode),
    .line_pixels(line_pixels),
    .line_memory(line_memory),
    .out_format(out_format)
  );
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic chk(logic [39:0] seen, logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial forever #4 clk_sys = ~clk_sys;
  // Watchdog sized well above the roughly 180 cycles the run needs
  initial begin
    #40000;
    n_fail++;
    tally_and_finish;
  end
  // Oldest expectation meets each finished read
  always @(negedge host_data_oe) if (reset_n) chk(host_data_out, exp_q.pop_front());
  initial begin
    repeat (5) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    chk({ctrl_reset, two_dim_coding, op_mode, line_pixels, line_memory, out_format}, 0);
    u_host_cpu_model.acc(1, 4'h6, 8'h01);
    chk(ctrl_reset, 1);
    u_host_cpu_model.acc(1, 4'h6, 8'hFE);
    chk(ctrl_reset, 0);
    // Last write hits the status address and must change nothing
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      v[i] = seed[7:0];
      u_host_cpu_model.acc(1, adr[i], v[i]);
    end
    chk({op_mode, line_pixels, line_memory, out_format, 7'h00, two_dim_coding},
        {v[0], v[1], v[2], v[3], 7'h00, v[4][0]});
    // Every enable pattern against random flags, then a status read and a read at an address from 8 to F
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      status_in = status_in_type'(seed[3:0]);
      u_host_cpu_model.acc(1, 4'h0, {4'h0, i[3:0]});
      chk(int_req, |(i[3:0] & seed[3:0]));
      exp_q.push_back({4'h0, seed[3:0]});
      u_host_cpu_model.acc(0, 4'h1, 8'h00);
      exp_q.push_back(8'h00);
      u_host_cpu_model.acc(0, {1'b1, seed[6:4]}, 8'h00);
    end
    // Mid-run reset with every flag up: registers and interrupt must clear
    status_in = status_in_type'(4'hF);
    reset_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    chk({ctrl_reset, two_dim_coding, op_mode, line_pixels, line_memory, out_format, int_req}, 0);
    exp_q.push_back(8'h0F);
    u_host_cpu_model.acc(0, 4'h1, 8'h00);
    // Every noted read must have been seen by the watcher
    chk(exp_q.size(), 0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
